// [verification/tb_usb_otg_core_config_regs.sv]
// Self-checking bench for the configuration register bank
`timescale 1ns/100ps
`default_nettype none
`include "ucfg_consts.svh"

module tb_usb_otg_core_config_regs
    import ucfg_pkg::*;
;
    localparam int WAIT = 20;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        ext_vbus_ind = 1'b0;
    logic        vbus_valid_int = 1'b0;
    logic [31:0] reg_rdata;
    logic [3:0]  dma_burst;
    logic [2:0]  ahb_hburst;
    logic [1:0]  role_force, if_ctrl;
    ucfg_ulpi_t  ulpi_ctrl;
    logic        core_irq_raw, core_irq, dma_mode_select, role_settled, transmit_tail_timer_en;
    logic        interchip_pull_detach, interchip_phy_select, srp_pulse_method, i2c_otg_select;
    logic        phy_low_power_clock_select, debug_packet_spoil;
    logic [31:0] rdata_ext;
    logic [3:0]  burst_ext;
    int          n_mismatch = 0;
    int          checks_done = 0;
    logic [3:0]  codes [5] = '{4'h1, 4'h3, 4'h7, 4'h2, 4'h0};
    logic [2:0]  hb [5] = '{3'h1, 3'h3, 3'h7, 3'h4, 3'h4};
    // Configuration outputs laid out at the bit positions of their register bits
    wire logic [31:0] obs = {debug_packet_spoil, role_force == UCFG_ROLE_DEV, role_force == UCFG_ROLE_HOST,
        transmit_tail_timer_en, interchip_pull_detach, interchip_phy_select, ulpi_ctrl.protect_disable,
        ulpi_ctrl.ind_bypass, ulpi_ctrl.ind_invert, srp_pulse_method, ulpi_ctrl.ext_overcurrent,
        ulpi_ctrl.ext_supply, ulpi_ctrl.clock_keep_alive, ulpi_ctrl.auto_wake, ulpi_ctrl.serial_mode,
        i2c_otg_select, phy_low_power_clock_select, 15'h0000};

    ucfg_regs #(.ROLE_WAIT_CYC(WAIT)) DUT (
        .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_irq_raw(core_irq_raw), .core_irq(core_irq),
        .dma_burst(dma_burst), .ahb_hburst(ahb_hburst), .dma_mode_select(dma_mode_select),
        .role_force(role_force), .role_settled(role_settled), .transmit_tail_timer_en(transmit_tail_timer_en),
        .interchip_pull_detach(interchip_pull_detach), .interchip_phy_select(interchip_phy_select),
        .ulpi_ctrl(ulpi_ctrl), .srp_pulse_method(srp_pulse_method), .i2c_otg_select(i2c_otg_select),
        .phy_low_power_clock_select(phy_low_power_clock_select), .debug_packet_spoil(debug_packet_spoil));

    ucfg_phy_model PHY (
        .ref_clk(ref_clk), .nrst(nrst), .ulpi_ctrl(ulpi_ctrl), .ext_vbus_ind(ext_vbus_ind),
        .vbus_valid_int(vbus_valid_int), .vbus_state(core_irq_raw), .if_ctrl(if_ctrl));

    // Second build: external DMA; role forcing, interchip, ULPI overcurrent and I2C left out
    ucfg_regs #(.EXT_DMA_BUILD(1'b1), .ROLE_BUILD(3), .interchip_build_option(1'b0), .hs_phy_build_option(0),
        .I2C_BUILD(1'b0), .ROLE_WAIT_CYC(WAIT)) DUT_EXT (
        .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata_ext), .core_irq_raw(core_irq_raw), .core_irq(), .dma_burst(burst_ext),
        .ahb_hburst(), .dma_mode_select(), .role_force(), .role_settled(), .transmit_tail_timer_en(),
        .interchip_pull_detach(), .interchip_phy_select(), .ulpi_ctrl(), .srp_pulse_method(), .i2c_otg_select(),
        .phy_low_power_clock_select(), .debug_packet_spoil());

    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic wrap_up;
    begin
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    // Extra edge after the strobe drops keeps back-to-back calls from driving one signal twice
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
    begin
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        @(posedge ref_clk);
    end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    begin
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata, exp);
        chk(rdata_ext, (a == `UCFG_OFF_USB_CFG) ? (exp & 32'h9BDEFFFF) : exp);
        @(posedge ref_clk);
    end
    endtask

    // Lets written values reach the outputs and the PHY model
    task automatic settle(input int n);
    begin
        repeat (n) @(posedge ref_clk);
    end
    endtask

    initial
    begin
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        settle(2);
        rd(`UCFG_OFF_BUS_CFG, 32'h0);
        rd(`UCFG_OFF_USB_CFG, 32'h0);
        rd(`UCFG_OFF_STATUS, 32'h1);
        chk(obs, 32'h0);
        // Bit 31 is never written: it spoils transmitted packets
        for (int b = 15; b <= 30; b++)
        begin
            wr(`UCFG_OFF_USB_CFG, 32'h1 << b);
            settle(2);
            chk(obs, (b == 27) ? 32'h0 : 32'h1 << b);
            rd(`UCFG_OFF_USB_CFG, 32'h1 << b);
            settle(WAIT + 10);
        end
        wr(`UCFG_OFF_USB_CFG, 32'h0C000000);
        settle(2);
        chk(obs, 32'h0C000000);
        wr(`UCFG_OFF_USB_CFG, 32'h60000000);
        settle(2);
        chk(obs, 32'h40000000);
        chk({31'h0, role_settled}, 32'h0);
        settle(WAIT + 10);
        chk({31'h0, role_settled}, 32'h1);
        rd(`UCFG_OFF_STATUS, 32'h1);
        wr(`UCFG_OFF_USB_CFG, 32'h000C0000);
        settle(3);
        chk({30'h0, if_ctrl}, 32'h3);
        for (int i = 0; i < 5; i++)
        begin
            wr(`UCFG_OFF_BUS_CFG, {26'h0, 1'b1, codes[i], 1'b0});
            settle(2);
            chk({24'h0, dma_burst, ahb_hburst, dma_mode_select}, {24'h0, 4'h0, hb[i], 1'b1});
            chk({28'h0, burst_ext}, {28'h0, codes[i]});
            rd(`UCFG_OFF_BUS_CFG, {26'h0, 1'b1, codes[i], 1'b0});
        end
        wr(`UCFG_OFF_BUS_CFG, 32'h0000000F);
        ext_vbus_ind   <= 1'b1;
        vbus_valid_int <= 1'b1;
        settle(6);
        chk({28'h0, ahb_hburst, dma_mode_select}, 32'h0);
        chk({31'h0, core_irq}, 32'h1);
        wr(`UCFG_OFF_USB_CFG, 32'h00800000);
        settle(6);
        chk({31'h0, core_irq}, 32'h0);
        wr(`UCFG_OFF_USB_CFG, 32'h01000000);
        vbus_valid_int <= 1'b0;
        settle(6);
        chk({31'h0, core_irq}, 32'h1);
        wr(`UCFG_OFF_BUS_CFG, 32'h0);
        settle(6);
        chk({31'h0, core_irq}, 32'h0);
        rd(`UCFG_OFF_STATUS, 32'h1);
        wr(`UCFG_OFF_BUS_CFG, 32'h1);
        settle(6);
        chk({31'h0, core_irq}, 32'h1);
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h0);
        rd(`UCFG_OFF_BUS_CFG, 32'h1);
        wrap_up;
    end

    // Tests need under 2000 cycles; the margin only catches a hang
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        wrap_up;
    end
endmodule

`default_nettype wire

// [verification/ucfg_phy_model.sv]
// Behavioural ULPI PHY model facing the configuration outputs
`timescale 1ns/100ps
`default_nettype none

module ucfg_phy_model
    import ucfg_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire ucfg_ulpi_t ulpi_ctrl,
    input  wire logic       ext_vbus_ind,
    input  wire logic       vbus_valid_int,
    output logic            vbus_state,
    output logic [1:0]      if_ctrl
);
    // Complement output, then optional qualification by the internal comparator
    wire logic compl_out  = ext_vbus_ind ^ ulpi_ctrl.ind_invert;
    wire logic next_state = compl_out & (vbus_valid_int | ulpi_ctrl.ind_bypass);

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            vbus_state <= 1'b0;
            if_ctrl    <= 2'b00;
        end
        else
        begin
            vbus_state <= next_state;
            if_ctrl    <= {ulpi_ctrl.clock_keep_alive, ulpi_ctrl.auto_wake};
        end
    end
endmodule

`default_nettype wire

// [verilog/ucfg_consts.svh]
// Offsets, field positions, reset values and timing counts of the configuration registers
`ifndef UCFG_CONSTS_SVH
`define UCFG_CONSTS_SVH
`define UCFG_ADDR_W           8
`define UCFG_OFF_BUS_CFG      8'h08
`define UCFG_OFF_USB_CFG      8'h0C
`define UCFG_OFF_STATUS       8'h10
`define UCFG_BUS_CFG_RESET    32'h00000000
`define UCFG_USB_CFG_RESET    32'h00000000
`define UCFG_BIT_INT_GATE     0
`define UCFG_BURST_LO         1
`define UCFG_BURST_HI         4
`define UCFG_BIT_DMA_MODE     5
`define UCFG_BIT_LOW_PWR_CLK  15
`define UCFG_BIT_I2C_SEL      16
`define UCFG_BIT_SERIAL_MODE  17
`define UCFG_BIT_AUTO_WAKE    18
`define UCFG_BIT_CLK_KEEP     19
`define UCFG_BIT_EXT_SUPPLY   20
`define UCFG_BIT_EXT_OVERCUR  21
`define UCFG_BIT_SRP_PULSE    22
`define UCFG_BIT_IND_INVERT   23
`define UCFG_BIT_IND_BYPASS   24
`define UCFG_BIT_PROT_DIS     25
`define UCFG_BIT_IC_SELECT    26
`define UCFG_BIT_IC_DETACH    27
`define UCFG_BIT_TAIL_TIMER   28
`define UCFG_BIT_FORCE_HOST   29
`define UCFG_BIT_FORCE_DEV    30
`define UCFG_BIT_SPOIL        31
`define UCFG_BURST_SINGLE     4'h0
`define UCFG_BURST_INCR       4'h1
`define UCFG_BURST_INCR4      4'h3
`define UCFG_BURST_INCR16     4'h7
`define UCFG_BURST_EXT4       4'h1
`define UCFG_BURST_EXT8       4'h2
`define UCFG_BURST_EXT256     4'h7
`define UCFG_HTRANS_W         3
`define UCFG_ROLE_WAIT_MS     25
`define UCFG_CLK_MHZ          250
`define UCFG_ROLE_WAIT_CYC    (`UCFG_ROLE_WAIT_MS * 1000 * `UCFG_CLK_MHZ)
`endif

// [verilog/ucfg_pkg.sv]
// Types shared by the configuration register block
package ucfg_pkg;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ucfg_req_t;

    typedef struct packed {
        logic clock_keep_alive;
        logic auto_wake;
        logic serial_mode;
        logic ext_supply;
        logic ext_overcurrent;
        logic ind_invert;
        logic ind_bypass;
        logic protect_disable;
    } ucfg_ulpi_t;

    typedef enum logic [1:0] {
        UCFG_ROLE_AUTO = 2'b00,
        UCFG_ROLE_DEV  = 2'b01,
        UCFG_ROLE_HOST = 2'b10
    } ucfg_role_t;

    typedef enum logic [2:0] {
        UCFG_HB_SINGLE = 3'b000,
        UCFG_HB_INCR   = 3'b001,
        UCFG_HB_INCR4  = 3'b011,
        UCFG_HB_INCR16 = 3'b111,
        UCFG_HB_BAD    = 3'b100
    } ucfg_hburst_t;
endpackage

// [verilog/ucfg_regs.sv]
// Configuration register bank of the dual-role USB controller
// Overview of operation
// - Bit5 picks DMA; zero when slave-only
// - External DMA: burst field drives burst port
// - Internal DMA: burst field picks master burst
// - Bit0 gates interrupt; status reads the gated interrupt
// - Bit30 forces device role, gated by build
// - Bit29 forces host role, gated by build
// - Bit28 enables transmit tail timers
// - Bit27 detaches pulls when interchip selected
// - Bit26 interchip select, writable only if built
// - Bit25 disables link protect circuit
// - Bit24 bypasses VBUS indication qualification
// - Bit23 inverts external VBUS indicator
// - Bit22 picks SRP pulse method
// - Bit21 external overcurrent, high-speed builds 2/3
// - Bit20 external VBUS supply select
// - Bit19 keeps PHY clock in suspend
// - Bit18 enables PHY auto wake
// - Bit17 selects PHY serial mode
// - Bit16 I2C select, writable only if built
// - Bit15 drives low power clock output
`timescale 1ns/100ps
`default_nettype none
`include "ucfg_consts.svh"

module ucfg_regs
    import ucfg_pkg::*;
#(
    parameter bit          DMA_BUILD            = 1'b1,
    parameter bit          EXT_DMA_BUILD        = 1'b0,
    parameter int unsigned ROLE_BUILD           = 0,
    parameter bit          interchip_build_option = 1'b1,
    parameter bit          FS_PHY_BUILD         = 1'b1,
    parameter int unsigned hs_phy_build_option  = 3,
    parameter bit          I2C_BUILD            = 1'b1,
    parameter int unsigned ROLE_WAIT_CYC        = `UCFG_ROLE_WAIT_CYC
)
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        core_irq_raw,
    output logic             core_irq,
    output logic [3:0]       dma_burst,
    output logic [2:0]       ahb_hburst,
    output logic             dma_mode_select,
    output logic [1:0]       role_force,
    output logic             role_settled,
    output logic             transmit_tail_timer_en,
    output logic             interchip_pull_detach,
    output logic             interchip_phy_select,
    output ucfg_ulpi_t       ulpi_ctrl,
    output logic             srp_pulse_method,
    output logic             i2c_otg_select,
    output logic             phy_low_power_clock_select,
    output logic             debug_packet_spoil
);
    logic [31:0] bus_cfg;
    logic [31:0] usb_cfg;
    logic [31:0] next_bus_cfg;
    logic [31:0] next_usb_cfg;
    logic [31:0] role_cnt;
    logic        irq_sync1;
    logic        irq_sync2;
    default clocking cfg_clk @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    wire ucfg_req_t req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    wire hit_bus    = req.addr == `UCFG_OFF_BUS_CFG;
    wire hit_usb    = req.addr == `UCFG_OFF_USB_CFG;
    wire hit_status = req.addr == `UCFG_OFF_STATUS;
    wire wr_bus     = req.wr && hit_bus;
    wire wr_usb     = req.wr && hit_usb;

    // Build gates: bits that a build lacks stay zero and so read as zero
    wire role_ok    = ROLE_BUILD <= 2;
    wire ic_sel_ok  = interchip_build_option && FS_PHY_BUILD;
    wire ulpi_ok    = hs_phy_build_option == 2 || hs_phy_build_option == 3;
    wire [31:0] bus_mask = {26'h0, DMA_BUILD, 5'h1F};
    wire [31:0] usb_mask = {1'b1, role_ok, role_ok, 1'b1, 1'b1, ic_sel_ok, 4'hF,
                            ulpi_ok, 4'hF, I2C_BUILD, 1'b1, 15'h0000};

    assign next_bus_cfg = wr_bus ? (req.wdata & bus_mask) : bus_cfg;
    assign next_usb_cfg = wr_usb ? (req.wdata & usb_mask) : usb_cfg;

    wire [3:0] burst  = bus_cfg[`UCFG_BURST_HI:`UCFG_BURST_LO];
    wire       is_dma = bus_cfg[`UCFG_BIT_DMA_MODE];

    // Only the INCR, INCR4 and INCR16 codes map; all other codes, single included, give a flagged value
    wire [2:0] next_hburst =
        (burst == `UCFG_BURST_INCR)   ? UCFG_HB_INCR :
        (burst == `UCFG_BURST_INCR4)  ? UCFG_HB_INCR4 :
        (burst == `UCFG_BURST_INCR16) ? UCFG_HB_INCR16 : UCFG_HB_BAD;
    wire [3:0] next_dma_burst = (is_dma && EXT_DMA_BUILD) ? burst : `UCFG_BURST_SINGLE;
    wire [2:0] sel_hburst = (is_dma && !EXT_DMA_BUILD) ? next_hburst : UCFG_HB_SINGLE;

    wire       f_dev  = usb_cfg[`UCFG_BIT_FORCE_DEV];
    wire       f_host = usb_cfg[`UCFG_BIT_FORCE_HOST];
    // Device wins if both are set; software is not meant to set both
    wire [1:0] next_role = f_dev ? UCFG_ROLE_DEV : (f_host ? UCFG_ROLE_HOST : UCFG_ROLE_AUTO);
    wire       role_chg  = next_role != role_force;
    wire       cnt_done  = role_cnt >= ROLE_WAIT_CYC;
    wire       ic_active = usb_cfg[`UCFG_BIT_IC_SELECT] && interchip_build_option;

    wire [31:0] rd_mux = hit_bus ? bus_cfg :
                         hit_usb ? usb_cfg :
                         hit_status ? {30'h0, core_irq, role_settled} : 32'h00000000;
    wire [31:0] next_rdata = req.rd ? rd_mux : 32'h00000000;

    ucfg_ulpi_t next_ulpi;
    assign next_ulpi = '{
        clock_keep_alive: usb_cfg[`UCFG_BIT_CLK_KEEP],
        auto_wake:        usb_cfg[`UCFG_BIT_AUTO_WAKE],
        serial_mode:      usb_cfg[`UCFG_BIT_SERIAL_MODE],
        ext_supply:       usb_cfg[`UCFG_BIT_EXT_SUPPLY],
        ext_overcurrent:  usb_cfg[`UCFG_BIT_EXT_OVERCUR],
        ind_invert:       usb_cfg[`UCFG_BIT_IND_INVERT],
        ind_bypass:       usb_cfg[`UCFG_BIT_IND_BYPASS],
        protect_disable:  usb_cfg[`UCFG_BIT_PROT_DIS]
    };

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            bus_cfg   <= `UCFG_BUS_CFG_RESET;
            usb_cfg   <= `UCFG_USB_CFG_RESET;
            reg_rdata <= 32'h00000000;
        end
        else
        begin
            bus_cfg   <= next_bus_cfg;
            usb_cfg   <= next_usb_cfg;
            reg_rdata <= next_rdata;
        end
    end

    // Interrupt source may come from another domain, so it is synchronised first
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            irq_sync1 <= 1'b0;
            irq_sync2 <= 1'b0;
            core_irq  <= 1'b0;
        end
        else
        begin
            irq_sync1 <= core_irq_raw;
            irq_sync2 <= irq_sync1;
            core_irq  <= irq_sync2 && bus_cfg[`UCFG_BIT_INT_GATE];
        end
    end

    // Settle counter only advises software; the role itself changes at once
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            role_force   <= UCFG_ROLE_AUTO;
            role_cnt     <= 32'(ROLE_WAIT_CYC); // Out of reset no role change is pending, so it starts settled
            role_settled <= 1'b1;
        end
        else
        begin
            role_force   <= next_role;
            role_cnt     <= role_chg ? 32'h00000000 : (cnt_done ? role_cnt : role_cnt + 32'h00000001);
            role_settled <= !role_chg && cnt_done;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            dma_burst                  <= `UCFG_BURST_SINGLE;
            ahb_hburst                 <= UCFG_HB_SINGLE;
            dma_mode_select            <= 1'b0;
            transmit_tail_timer_en     <= 1'b0;
            interchip_pull_detach      <= 1'b0;
            interchip_phy_select       <= 1'b0;
            ulpi_ctrl                  <= '0;
            srp_pulse_method           <= 1'b0;
            i2c_otg_select             <= 1'b0;
            phy_low_power_clock_select <= 1'b0;
            debug_packet_spoil         <= 1'b0;
        end
        else
        begin
            dma_burst                  <= next_dma_burst;
            ahb_hburst                 <= sel_hburst;
            dma_mode_select            <= is_dma;
            transmit_tail_timer_en     <= usb_cfg[`UCFG_BIT_TAIL_TIMER];
            interchip_pull_detach      <= usb_cfg[`UCFG_BIT_IC_DETACH] && ic_active;
            interchip_phy_select       <= ic_active;
            ulpi_ctrl                  <= next_ulpi;
            srp_pulse_method           <= usb_cfg[`UCFG_BIT_SRP_PULSE];
            i2c_otg_select             <= usb_cfg[`UCFG_BIT_I2C_SEL];
            phy_low_power_clock_select <= usb_cfg[`UCFG_BIT_LOW_PWR_CLK];
            debug_packet_spoil         <= usb_cfg[`UCFG_BIT_SPOIL];
        end
    end

    a_dma_mode_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
        !DMA_BUILD |-> !bus_cfg[`UCFG_BIT_DMA_MODE]) else $error("dma mode set in slave build");
    a_ext_burst_out: assert property (@(posedge ref_clk) disable iff (!nrst)
        (EXT_DMA_BUILD && is_dma) |=> dma_burst == $past(burst)) else $error("burst port mismatch");
    a_int_burst_map: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!EXT_DMA_BUILD && is_dma && burst == `UCFG_BURST_INCR4) |=> ahb_hburst == UCFG_HB_INCR4)
        else $error("incr4 not mapped");
    a_irq_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
        !bus_cfg[`UCFG_BIT_INT_GATE] |=> !core_irq) else $error("interrupt leaked through gate");
    a_irq_pass: assert property (@(posedge ref_clk) disable iff (!nrst)
        (core_irq_raw && bus_cfg[`UCFG_BIT_INT_GATE])[*4] |-> core_irq) else $error("interrupt not passed");
    a_role_dev_wr: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_usb && req.wdata[`UCFG_BIT_FORCE_DEV] && role_ok) |-> ##2 role_force == UCFG_ROLE_DEV)
        else $error("device role not forced");
    a_role_host_wr: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_usb && req.wdata[`UCFG_BIT_FORCE_HOST] && !req.wdata[`UCFG_BIT_FORCE_DEV] && role_ok)
        |-> ##2 role_force == UCFG_ROLE_HOST) else $error("host role not forced");
    a_role_settle: assert property (@(posedge ref_clk) disable iff (!nrst)
        $changed(role_force) |-> !role_settled) else $error("settled too early");
    a_ic_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
        !ic_sel_ok |-> !usb_cfg[`UCFG_BIT_IC_SELECT]) else $error("interchip select writable");
    a_detach_need: assert property (@(posedge ref_clk) disable iff (!nrst)
        interchip_pull_detach |-> $past(usb_cfg[`UCFG_BIT_IC_SELECT])) else $error("detach without select");
    a_i2c_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
        !I2C_BUILD |-> !i2c_otg_select) else $error("i2c select without build");
    a_read_latency: assert property (@(posedge ref_clk) disable iff (!nrst)
        (req.rd && hit_usb) |=> reg_rdata == $past(usb_cfg)) else $error("read data wrong");

    // Stored bits reach their outputs one edge later; gated bits never store
    a_tail_copy: assert property (
        transmit_tail_timer_en == $past(usb_cfg[`UCFG_BIT_TAIL_TIMER]))
        else $error("tail timer enable wrong");

    a_spoil_copy: assert property (
        debug_packet_spoil == $past(usb_cfg[`UCFG_BIT_SPOIL]))
        else $error("packet spoil output wrong");

    a_srp_copy: assert property (
        srp_pulse_method == $past(usb_cfg[`UCFG_BIT_SRP_PULSE]))
        else $error("srp pulse method wrong");

    a_lowpwr_copy: assert property (
        phy_low_power_clock_select == $past(usb_cfg[`UCFG_BIT_LOW_PWR_CLK]))
        else $error("low power clock select wrong");

    a_i2c_copy: assert property (
        i2c_otg_select == $past(usb_cfg[`UCFG_BIT_I2C_SEL]))
        else $error("i2c select output wrong");

    a_protect_copy: assert property (
        ulpi_ctrl.protect_disable == $past(usb_cfg[`UCFG_BIT_PROT_DIS]))
        else $error("protect disable wrong");

    a_bypass_copy: assert property (
        ulpi_ctrl.ind_bypass == $past(usb_cfg[`UCFG_BIT_IND_BYPASS]))
        else $error("indication bypass wrong");

    a_invert_copy: assert property (
        ulpi_ctrl.ind_invert == $past(usb_cfg[`UCFG_BIT_IND_INVERT]))
        else $error("indication invert wrong");

    a_overcur_copy: assert property (
        ulpi_ctrl.ext_overcurrent == $past(usb_cfg[`UCFG_BIT_EXT_OVERCUR]))
        else $error("overcurrent select wrong");

    a_supply_copy: assert property (
        ulpi_ctrl.ext_supply == $past(usb_cfg[`UCFG_BIT_EXT_SUPPLY]))
        else $error("vbus supply select wrong");

    a_clk_keep_copy: assert property (
        ulpi_ctrl.clock_keep_alive == $past(usb_cfg[`UCFG_BIT_CLK_KEEP]))
        else $error("clock keep alive wrong");

    a_wake_copy: assert property (
        ulpi_ctrl.auto_wake == $past(usb_cfg[`UCFG_BIT_AUTO_WAKE]))
        else $error("auto wake wrong");

    a_serial_copy: assert property (
        ulpi_ctrl.serial_mode == $past(usb_cfg[`UCFG_BIT_SERIAL_MODE]))
        else $error("serial mode wrong");

    a_ic_sel_copy: assert property (
        interchip_phy_select == $past(usb_cfg[`UCFG_BIT_IC_SELECT]))
        else $error("interchip select wrong");

    a_detach_gate: assert property (
        interchip_pull_detach |-> interchip_phy_select)
        else $error("detach while interchip off");

    a_dma_copy: assert property (
        dma_mode_select == $past(bus_cfg[`UCFG_BIT_DMA_MODE]))
        else $error("dma mode output wrong");

    a_slave_burst: assert property (
        !$past(bus_cfg[`UCFG_BIT_DMA_MODE]) |-> dma_burst == `UCFG_BURST_SINGLE && ahb_hburst == UCFG_HB_SINGLE)
        else $error("burst driven in slave mode");

    a_incr_map: assert property (
        (!EXT_DMA_BUILD && is_dma && burst == `UCFG_BURST_INCR) |=> ahb_hburst == UCFG_HB_INCR)
        else $error("incr not mapped");

    a_incr16_map: assert property (
        (!EXT_DMA_BUILD && is_dma && burst == `UCFG_BURST_INCR16) |=> ahb_hburst == UCFG_HB_INCR16)
        else $error("incr16 not mapped");

    a_rsvd_burst: assert property (
        (!EXT_DMA_BUILD && is_dma && burst == 4'h2) |=> ahb_hburst == UCFG_HB_BAD)
        else $error("reserved burst not flagged");

    a_ext_no_hburst: assert property (
        EXT_DMA_BUILD |-> ahb_hburst == UCFG_HB_SINGLE)
        else $error("master burst in external mode");

    a_role_gate: assert property (
        !role_ok |-> role_force == UCFG_ROLE_AUTO)
        else $error("role forced without build");

    a_role_auto: assert property (
        (wr_usb && !req.wdata[`UCFG_BIT_FORCE_DEV] && !req.wdata[`UCFG_BIT_FORCE_HOST]) |-> ##2 role_force == UCFG_ROLE_AUTO)
        else $error("role not released");

    a_settle_fall: assert property (
        $fell(role_settled) |-> $changed(role_force))
        else $error("settled dropped without role change");

    a_irq_drop: assert property (
        !irq_sync2 |=> !core_irq)
        else $error("interrupt without source");

    a_rdata_idle: assert property (
        !req.rd |=> reg_rdata == 32'h00000000)
        else $error("read data outside read slot");

    a_read_bus: assert property (
        (req.rd && hit_bus) |=> reg_rdata == $past(bus_cfg))
        else $error("bus cfg read wrong");

    a_read_status: assert property (
        (req.rd && hit_status) |=> reg_rdata == {30'h0, $past(core_irq), $past(role_settled)})
        else $error("status read wrong");

    a_read_unmapped: assert property (
        (req.rd && !hit_bus && !hit_usb && !hit_status) |=> reg_rdata == 32'h00000000)
        else $error("unmapped read not zero");

    a_bus_write: assert property (
        wr_bus |=> bus_cfg[`UCFG_BURST_HI:0] == $past(req.wdata[`UCFG_BURST_HI:0]))
        else $error("bus cfg write lost");

    a_bus_hold: assert property (
        !wr_bus |=> $stable(bus_cfg))
        else $error("bus cfg changed without write");

    a_usb_hold: assert property (
        !wr_usb |=> $stable(usb_cfg))
        else $error("usb cfg changed without write");

    a_bus_upper_zero: assert property (
        bus_cfg[31:6] == 26'h0000000)
        else $error("bus cfg upper bits set");

    a_usb_lower_zero: assert property (
        usb_cfg[14:0] == 15'h0000)
        else $error("usb cfg lower bits set");

    a_ulpi_gate: assert property (
        !ulpi_ok |-> !usb_cfg[`UCFG_BIT_EXT_OVERCUR])
        else $error("overcurrent select without build");

    a_role_bit_gate: assert property (
        !role_ok |-> usb_cfg[`UCFG_BIT_FORCE_DEV:`UCFG_BIT_FORCE_HOST] == 2'b00)
        else $error("force bits stored without build");

    c_dma_on:  cover property (@(posedge ref_clk) disable iff (!nrst) $rose(dma_mode_select));
    c_dev_set: cover property (@(posedge ref_clk) disable iff (!nrst) role_force == UCFG_ROLE_DEV);
    c_irq_out: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(core_irq));
    c_settled: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(role_settled));
    c_ext_burst: cover property (@(posedge ref_clk) disable iff (!nrst) EXT_DMA_BUILD && dma_burst == 4'h7);
endmodule
`default_nettype wire
